/* File: design/but_pkg.sv */
/*
 * Shared constants and types of the basic update timer: register offsets,
 * field positions, reset values and trigger-source encodings.
 * Assumes a 16-bit register data path with byte addresses on an 8-bit bus.
 */
package but_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int CNT_W  = 16;
    localparam int PSC_W  = 16;
    localparam int MMS_W  = 3;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [ADDR_W-1:0] OFS_CONTROL_ONE   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CONTROL_TWO   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_ENABLE        = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_STATUS_FLAG   = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_EVENT_TRIGGER = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_COUNTER_VALUE = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_PRESCALE     = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_RELOAD_VALUE  = 8'h2c;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int BIT_COUNTER_ENABLE = 0;
    localparam int BIT_UPDATE_DISABLE = 1;
    localparam int BIT_REQUEST_SOURCE = 2;
    localparam int BIT_ONE_PULSE      = 3;
    localparam int BIT_RELOAD_BUFFER  = 7;
    localparam int BIT_MMS_LSB        = 4;
    localparam int BIT_IRQ_ENABLE     = 0;
    localparam int BIT_DMA_ENABLE     = 8;
    localparam int BIT_UPDATE_FLAG    = 0;
    localparam int BIT_UPDATE_GEN     = 0;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [CNT_W-1:0]  RST_COUNTER  = 16'h0000;
    localparam logic [PSC_W-1:0]  RST_PRESCALE = 16'h0000;
    localparam logic [CNT_W-1:0]  RST_RELOAD   = 16'hffff;
    localparam logic [DATA_W-1:0] RD_IDLE      = 16'h0000;

    // ************************************************************
    // Trigger output sources
    // ************************************************************
    typedef enum logic [MMS_W-1:0] {
        MMS_RESET  = 3'h0,
        MMS_ENABLE = 3'h1,
        MMS_UPDATE = 3'h2
    } but_mms_e;

    // ************************************************************
    // Control fields
    // ************************************************************
    typedef struct packed {
        logic reload_buffer_enable;
        logic one_pulse;
        logic update_request_source;
        logic update_disable;
        logic counter_enable_bit;
    } but_ctrl_s;

    localparam but_ctrl_s RST_CTRL = 5'h00;

endpackage

/* File: design/but_timer.sv */
/*
 * Basic update timer: 16-bit auto-reload upcounter fed by a buffered
 * 16-bit prescaler, with update flag, interrupt and DMA request outputs
 * and a trigger output for a converter or slave timers.
 * Assumes a register master on the same clock with one-cycle strobes and
 * a slave mode controller, if any, driving slave_update_req on clk.
 */
// Implementation choices: the plain strobed port and the register addresses.
// Summary of operation
// - 16-bit auto-reload counter clocked by prescaler
// - 16-bit prescaler divides clock by 1..65536
// - Counter, reload, prescale readable and writable anytime
// - Reload accesses hit preload, not shadow
// - Preload copies continuously, or at update if buffered
// - Overflow makes update event unless updates disabled
// - Counter advances only on enabled prescaler tick
// - Run signal follows enable one cycle later
// - New prescale ratio applies at next update
// - Count 0 to reload, wrap, flag overflow
// - Generate command or slave request makes update
// - Disabled updates keep shadows; generate still restarts
// - Request source set: generate updates without flag
// - Update event sets update flag per source
// - Update loads prescale buffer and reload shadow
// - Trigger output paces the converter
// - Overflow update can raise interrupt or DMA
// - Instance self-contained, nothing shared
// - Buffer control 0 immediate, 1 until update
// - Hardware sets flag, software clears it
// - Flag interrupts only while interrupt enabled
// - Update source selected drives trigger output
`timescale 1ns/1ns

module but_timer #(
    parameter int CNT_W = but_pkg::CNT_W,
    parameter int PSC_W = but_pkg::PSC_W
) (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       clk_en,
    input  wire logic [but_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [but_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [but_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic                       slave_update_req,
    output logic                            update_irq,
    output logic                            update_dma_req,
    output logic                            trigger_output
);

    // ************************************************************
    // State
    // ************************************************************
    but_pkg::but_ctrl_s              ctrl_q;
    logic [but_pkg::MMS_W-1:0]       master_mode_select_q;
    logic                            update_irq_enable_q;
    logic                            update_dma_enable_q;
    logic                            update_flag_q;
    logic                            counter_run_signal_q;
    logic [CNT_W-1:0]                counter_value_q;
    logic [PSC_W-1:0]                prescale_ratio_q;
    logic [PSC_W-1:0]                prescale_buffer_q;
    logic [PSC_W-1:0]                prescale_count_q;
    logic [CNT_W-1:0]                reload_value_q;
    logic [CNT_W-1:0]                reload_shadow_q;
    logic [but_pkg::DATA_W-1:0]      reg_rdata_q;
    logic                            dma_req_q;
    logic                            trigger_q;

    // ************************************************************
    // Decode
    // ************************************************************
    logic wr_ctrl_one;
    logic wr_ctrl_two;
    logic wr_enable;
    logic wr_status;
    logic wr_event;
    logic wr_counter;
    logic wr_prescale;
    logic wr_reload;

    assign wr_ctrl_one = reg_wr && (reg_addr == but_pkg::OFS_CONTROL_ONE);
    assign wr_ctrl_two = reg_wr && (reg_addr == but_pkg::OFS_CONTROL_TWO);
    assign wr_enable   = reg_wr && (reg_addr == but_pkg::OFS_ENABLE);
    assign wr_status   = reg_wr && (reg_addr == but_pkg::OFS_STATUS_FLAG);
    assign wr_event    = reg_wr && (reg_addr == but_pkg::OFS_EVENT_TRIGGER);
    assign wr_counter  = reg_wr && (reg_addr == but_pkg::OFS_COUNTER_VALUE);
    assign wr_prescale = reg_wr && (reg_addr == but_pkg::OFS_PRESCALE);
    assign wr_reload   = reg_wr && (reg_addr == but_pkg::OFS_RELOAD_VALUE);

    // ************************************************************
    // Events
    // ************************************************************
    logic update_generate_cmd;
    logic count_clock_tick;
    logic counter_overflow;
    logic update_event;
    logic flag_set;

    // Write pulse only: nothing is stored, so the bit reads zero
    assign update_generate_cmd =
        (wr_event && reg_wdata[but_pkg::BIT_UPDATE_GEN])
        || slave_update_req;

    assign count_clock_tick = counter_run_signal_q
        && (prescale_count_q == prescale_buffer_q);

    assign counter_overflow = count_clock_tick
        && (counter_value_q == reload_shadow_q);

    assign update_event = !ctrl_q.update_disable
        && (counter_overflow || update_generate_cmd);

    // Generated updates set the flag only when the source allows it
    assign flag_set = !ctrl_q.update_disable
        && (counter_overflow
            || (update_generate_cmd
                && !ctrl_q.update_request_source));

    // ************************************************************
    // Control registers
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= but_pkg::RST_CTRL;
        end else if (clk_en) begin
            if (wr_ctrl_one) begin
                ctrl_q.counter_enable_bit <=
                    reg_wdata[but_pkg::BIT_COUNTER_ENABLE];
                ctrl_q.update_disable <=
                    reg_wdata[but_pkg::BIT_UPDATE_DISABLE];
                ctrl_q.update_request_source <=
                    reg_wdata[but_pkg::BIT_REQUEST_SOURCE];
                ctrl_q.one_pulse <= reg_wdata[but_pkg::BIT_ONE_PULSE];
                ctrl_q.reload_buffer_enable <=
                    reg_wdata[but_pkg::BIT_RELOAD_BUFFER];
            end
            // One-pulse mode stops the counter at its update
            if (update_event && ctrl_q.one_pulse) begin
                ctrl_q.counter_enable_bit <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            master_mode_select_q <= but_pkg::MMS_RESET;
            update_irq_enable_q  <= 1'b0;
            update_dma_enable_q  <= 1'b0;
        end else if (clk_en) begin
            if (wr_ctrl_two) begin
                master_mode_select_q <=
                    reg_wdata[but_pkg::BIT_MMS_LSB +: but_pkg::MMS_W];
            end
            if (wr_enable) begin
                update_irq_enable_q <= reg_wdata[but_pkg::BIT_IRQ_ENABLE];
                update_dma_enable_q <= reg_wdata[but_pkg::BIT_DMA_ENABLE];
            end
        end
    end

    // ************************************************************
    // Counter run signal
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            counter_run_signal_q <= 1'b0;
        end else if (clk_en) begin
            counter_run_signal_q <= ctrl_q.counter_enable_bit;
        end
    end

    // ************************************************************
    // Prescaler
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale_ratio_q <= but_pkg::RST_PRESCALE;
        end else if (clk_en) begin
            if (wr_prescale) begin
                prescale_ratio_q <= reg_wdata[PSC_W-1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale_buffer_q <= but_pkg::RST_PRESCALE;
        end else if (clk_en) begin
            if (update_event) begin
                prescale_buffer_q <= prescale_ratio_q;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale_count_q <= but_pkg::RST_PRESCALE;
        end else if (clk_en) begin
            // Restart happens even with updates disabled
            if (update_generate_cmd) begin
                prescale_count_q <= '0;
            end else if (count_clock_tick) begin
                prescale_count_q <= '0;
            end else if (counter_run_signal_q) begin
                prescale_count_q <= prescale_count_q + 1'b1;
            end
        end
    end

    // ************************************************************
    // Counter
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            counter_value_q <= but_pkg::RST_COUNTER;
        end else if (clk_en) begin
            if (wr_counter) begin
                counter_value_q <= reg_wdata[CNT_W-1:0];
            end else if (update_generate_cmd) begin
                counter_value_q <= '0;
            end else if (counter_overflow) begin
                counter_value_q <= '0;
            end else if (count_clock_tick) begin
                counter_value_q <= counter_value_q + 1'b1;
            end
        end
    end

    // ************************************************************
    // Auto-reload
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reload_value_q <= but_pkg::RST_RELOAD;
        end else if (clk_en) begin
            if (wr_reload) begin
                reload_value_q <= reg_wdata[CNT_W-1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reload_shadow_q <= but_pkg::RST_RELOAD;
        end else if (clk_en) begin
            if (!ctrl_q.reload_buffer_enable) begin
                reload_shadow_q <= reload_value_q;
            end else if (update_event) begin
                reload_shadow_q <= reload_value_q;
            end
        end
    end

    // ************************************************************
    // Update flag and requests
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            update_flag_q <= 1'b0;
        end else if (clk_en) begin
            // A set in the clearing cycle wins
            if (flag_set) begin
                update_flag_q <= 1'b1;
            end else if (wr_status
                         && !reg_wdata[but_pkg::BIT_UPDATE_FLAG]) begin
                update_flag_q <= 1'b0;
            end
        end
    end

    assign update_irq = update_flag_q && update_irq_enable_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dma_req_q <= 1'b0;
        end else if (clk_en) begin
            dma_req_q <= flag_set && update_dma_enable_q;
        end
    end

    assign update_dma_req = dma_req_q;

    // ************************************************************
    // Trigger output
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trigger_q <= 1'b0;
        end else if (clk_en) begin
            case (master_mode_select_q)
                but_pkg::MMS_RESET: begin
                    trigger_q <= update_generate_cmd;
                end
                but_pkg::MMS_ENABLE: begin
                    trigger_q <= counter_run_signal_q;
                end
                but_pkg::MMS_UPDATE: begin
                    trigger_q <= update_event;
                end
                default: begin
                    trigger_q <= 1'b0;
                end
            endcase
        end
    end

    assign trigger_output = trigger_q;

    // ************************************************************
    // Read port
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q <= but_pkg::RD_IDLE;
        end else if (clk_en) begin
            reg_rdata_q <= but_pkg::RD_IDLE;
            if (reg_rd) begin
                case (reg_addr)
                    but_pkg::OFS_CONTROL_ONE: begin
                        reg_rdata_q[but_pkg::BIT_COUNTER_ENABLE] <=
                            ctrl_q.counter_enable_bit;
                        reg_rdata_q[but_pkg::BIT_UPDATE_DISABLE] <=
                            ctrl_q.update_disable;
                        reg_rdata_q[but_pkg::BIT_REQUEST_SOURCE] <=
                            ctrl_q.update_request_source;
                        reg_rdata_q[but_pkg::BIT_ONE_PULSE] <=
                            ctrl_q.one_pulse;
                        reg_rdata_q[but_pkg::BIT_RELOAD_BUFFER] <=
                            ctrl_q.reload_buffer_enable;
                    end
                    but_pkg::OFS_CONTROL_TWO: begin
                        reg_rdata_q[but_pkg::BIT_MMS_LSB +: but_pkg::MMS_W]
                            <= master_mode_select_q;
                    end
                    but_pkg::OFS_ENABLE: begin
                        reg_rdata_q[but_pkg::BIT_IRQ_ENABLE] <=
                            update_irq_enable_q;
                        reg_rdata_q[but_pkg::BIT_DMA_ENABLE] <=
                            update_dma_enable_q;
                    end
                    but_pkg::OFS_STATUS_FLAG: begin
                        reg_rdata_q[but_pkg::BIT_UPDATE_FLAG] <=
                            update_flag_q;
                    end
                    but_pkg::OFS_COUNTER_VALUE: begin
                        reg_rdata_q[CNT_W-1:0] <= counter_value_q;
                    end
                    but_pkg::OFS_PRESCALE: begin
                        reg_rdata_q[PSC_W-1:0] <= prescale_ratio_q;
                    end
                    but_pkg::OFS_RELOAD_VALUE: begin
                        reg_rdata_q[CNT_W-1:0] <= reload_value_q;
                    end
                    default: begin
                        reg_rdata_q <= but_pkg::RD_IDLE;
                    end
                endcase
            end
        end
    end

    assign reg_rdata = reg_rdata_q;

endmodule

/* File: testbench/but_timer_properties.sv */
/* Port checker of the basic update timer, bound into every but_timer.
   Assumes one clock domain and tracks control writes on its own. */
`timescale 1ns/1ns

module but_timer_properties #(
    parameter int CNT_W = 16,
    parameter int PSC_W = 16
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        clk_en,
    input wire logic [7:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        slave_update_req,
    input wire logic        update_irq,
    input wire logic        update_dma_req,
    input wire logic        trigger_output
);
    logic [2:0] mode_q;
    logic       update_disable_q;
    logic       en_q;
    logic       irq_en_q;
    wire        gen_w = reg_wr && reg_wdata[0]
                        && reg_addr == but_pkg::OFS_EVENT_TRIGGER;

    // Shadow of the control fields as software last wrote them
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q   <= 3'h0;
            update_disable_q   <= 1'b0;
            en_q     <= 1'b0;
            irq_en_q <= 1'b0;
        end else if (reg_wr && clk_en) begin
            if (reg_addr == but_pkg::OFS_CONTROL_ONE) begin
                en_q   <= reg_wdata[0];
                update_disable_q <= reg_wdata[1];
            end
            if (reg_addr == but_pkg::OFS_CONTROL_TWO)
                mode_q <= reg_wdata[6:4];
            if (reg_addr == but_pkg::OFS_ENABLE)
                irq_en_q <= reg_wdata[0];
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence start_s;
        reg_wr && reg_addr == but_pkg::OFS_CONTROL_ONE && reg_wdata[0]
            && !en_q && mode_q == 3'h1;
    endsequence
    sequence run_late_s;
        !trigger_output [*2] ##1 trigger_output;
    endsequence

    read_idle_zero_a: assert property (!$past(reg_rd) |->
        reg_rdata == 16'h0000) else $error("read data outside read cycle");
    event_reads_zero_a: assert property (reg_rd &&
        reg_addr == but_pkg::OFS_EVENT_TRIGGER |=> reg_rdata == 16'h0000)
        else $error("event register read not zero");
    irq_gated_a: assert property (update_irq |-> irq_en_q)
        else $error("interrupt while disabled");
    dma_one_cycle_a: assert property (update_dma_req |=>
        !update_dma_req) else $error("dma request too long");
    dma_with_trigger_a: assert property (update_dma_req &&
        $past(mode_q) == 3'h2 |-> trigger_output)
        else $error("dma request without update");
    gen_trigger_a: assert property (gen_w && mode_q == 3'h0
        |=> trigger_output) else $error("no trigger on generate");
    gen_update_a: assert property ((gen_w || slave_update_req)
        && mode_q == 3'h2 && !update_disable_q |=> trigger_output)
        else $error("no update after generate");
    update_disable_blocks_a: assert property (mode_q == 3'h2 && update_disable_q
        |=> !trigger_output) else $error("update while disabled");
    idle_modes_a: assert property (mode_q > 3'h2
        |=> !trigger_output) else $error("trigger in idle mode");
    run_delay_a: assert property (start_s |=> run_late_s)
        else $error("run signal timing wrong");
endmodule

bind but_timer but_timer_properties #(.CNT_W(CNT_W), .PSC_W(PSC_W)) u_prop (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .slave_update_req(slave_update_req),
    .update_irq(update_irq), .update_dma_req(update_dma_req),
    .trigger_output(trigger_output));

/* File: testbench/but_trigger_sink.sv */
/* Converter trigger input: counts trigger cycles and the gap between them.
   Assumes the timer clock and reset. */
`timescale 1ns/1ns

module but_trigger_sink (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        trigger_output,
    output logic      [15:0] pulse_count,
    output logic      [15:0] pulse_gap
);
    logic [15:0] since_q;

    // One conversion start per sampled trigger cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_count <= 16'h0000;
            pulse_gap   <= 16'h0000;
            since_q     <= 16'h0000;
        end else if (trigger_output) begin
            pulse_count <= pulse_count + 16'h0001;
            pulse_gap   <= since_q;
            since_q     <= 16'h0001;
        end else begin
            since_q <= since_q + 16'h0001;
        end
    end
endmodule

/* File: testbench/basic_update_timer_test.sv */
/* Self-checking bench of the basic update timer.
   Assumes the design package, the trigger sink and the bound checker. */
`timescale 1ns/1ns

module basic_update_timer_test;
    logic        clk, rst_n, clk_en, reg_wr, reg_rd, slave_update_req;
    logic        update_irq, update_dma_req, trigger_output;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, pulse_count, pulse_gap;
    int          bad_count;
    int          n_tests;
    int          cycles;
    localparam logic [7:0] C1  = but_pkg::OFS_CONTROL_ONE;
    localparam logic [7:0] EG  = but_pkg::OFS_EVENT_TRIGGER;
    localparam logic [7:0] SR  = but_pkg::OFS_STATUS_FLAG;
    localparam logic [7:0] ARR = but_pkg::OFS_RELOAD_VALUE;
    localparam logic [7:0] CNT = but_pkg::OFS_COUNTER_VALUE;

    but_timer DUT (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .update_irq(update_irq),
        .slave_update_req(slave_update_req), .update_dma_req(update_dma_req),
        .trigger_output(trigger_output));
    but_trigger_sink u_sink (.clk(clk), .rst_n(rst_n),
        .trigger_output(trigger_output), .pulse_count(pulse_count),
        .pulse_gap(pulse_gap));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk) reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk) reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic chk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd(a, d);
        check(d, exp);
    endtask

    task automatic wait_pulse();
        logic [15:0] c;
        c = pulse_count;
        for (int i = 0; i < 300 && pulse_count === c; i++)
            @(posedge clk) #1;
    endtask

    // Counter advance over eight clock edges
    task automatic advance(output logic [15:0] diff);
        logic [15:0] a;
        logic [15:0] b;
        rd(CNT, a);
        repeat (7) @(posedge clk);
        rd(CNT, b);
        diff = b - a;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        chk(CNT, but_pkg::RST_COUNTER);
        chk(but_pkg::OFS_PRESCALE, but_pkg::RST_PRESCALE);
        chk(ARR, but_pkg::RST_RELOAD);
        chk(SR, 16'h0000);
        chk(EG, 16'h0000);
        chk(8'h08, but_pkg::RD_IDLE);
        wr(CNT, 16'h0002);
        chk(CNT, 16'h0002);
        wr(ARR, 16'h0003);
        chk(ARR, 16'h0003);
    endtask

    task automatic t_count();
        wr(but_pkg::OFS_CONTROL_TWO, 16'h0010);
        wr(but_pkg::OFS_ENABLE, 16'h0101);
        wr(C1, 16'h0001);
        repeat (3) @(posedge clk);
        #1 check(16'(trigger_output), 16'h0001);
        wr(but_pkg::OFS_CONTROL_TWO, 16'h0020);
        repeat (3) wait_pulse();
        check(pulse_gap, 16'h0004);
        wr(C1, 16'h0000);
        check(16'(update_irq), 16'h0001);
        chk(SR, 16'h0001);
        wr(SR, 16'h0000);
        chk(SR, 16'h0000);
        check(16'(update_irq), 16'h0000);
        wr(but_pkg::OFS_ENABLE, 16'h0100);
        wr(EG, 16'h0001);
        check(16'(update_dma_req), 16'h0001);
        chk(SR, 16'h0001);
        check(16'(update_irq), 16'h0000);
        wr(SR, 16'h0000);
    endtask

    task automatic t_prescale();
        logic [15:0] d;
        wr(ARR, 16'h00ff);
        wr(but_pkg::OFS_PRESCALE, 16'h0001);
        wr(EG, 16'h0001);
        wr(C1, 16'h0001);
        advance(d);
        check(d, 16'h0003);
        wr(C1, 16'h0003);
        wr(but_pkg::OFS_PRESCALE, 16'h0003);
        wr(EG, 16'h0001);
        rd(CNT, d);
        check(16'(d < 16'h0002), 16'h0001);
        advance(d);
        check(d, 16'h0004);
        wr(C1, 16'h0001);
        wr(EG, 16'h0001);
        advance(d);
        check(d, 16'h0002);
        wr(C1, 16'h0000);
    endtask

    task automatic t_buffer();
        wr(but_pkg::OFS_PRESCALE, 16'h0000);
        wr(ARR, 16'h0003);
        wr(EG, 16'h0001);
        wr(C1, 16'h0081);
        wait_pulse();
        wr(ARR, 16'h0007);
        wait_pulse();
        check(pulse_gap, 16'h0004);
        wait_pulse();
        check(pulse_gap, 16'h0008);
        chk(ARR, 16'h0007);
        wr(C1, 16'h0001);
        wait_pulse();
        wr(ARR, 16'h0003);
        wait_pulse();
        check(pulse_gap, 16'h0004);
        wr(C1, 16'h0000);
    endtask

    task automatic t_sources();
        logic [15:0] c;
        logic [15:0] e;
        logic [2:0]  m;
        wr(SR, 16'h0000);
        wr(C1, 16'h0004);
        for (int i = 0; i < 4; i++) begin
            m = (i == 3) ? 3'h5 : 3'(i);
            e = (m == 3'h0 || m == 3'h2) ? 16'h0001 : 16'h0000;
            wr(but_pkg::OFS_CONTROL_TWO, {9'h000, m, 4'h0});
            c = pulse_count;
            wr(EG, 16'h0001);
            repeat (2) @(posedge clk);
            #1 check(pulse_count - c, e);
        end
        wr(but_pkg::OFS_CONTROL_TWO, 16'h0020);
        c = pulse_count;
        slave_update_req <= 1'b1;
        @(posedge clk) slave_update_req <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check(pulse_count - c, 16'h0001);
        chk(SR, 16'h0000);
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            print_verdict();
        end
    end

    initial begin
        {rst_n, reg_wr, reg_rd, slave_update_req} = 4'h0;
        clk_en    = 1'b1;
        reg_addr  = 8'h00;
        reg_wdata = 16'h0000;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk) #1;
        t_reset();
        t_count();
        t_prescale();
        t_buffer();
        t_sources();
        print_verdict();
    end
endmodule
